// >>> lvdc_top.sv
// The Avalon-MM register port was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module lvdc_top (
	input  wire logic        mclk,
	input  wire logic        reset,
	input  wire logic [1:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [3:0]  avs_byteenable,
	input  wire logic [31:0] avs_writedata,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic        regulator_enable_pin,
	input  wire logic        stop_mode,
	input  wire logic        detect_below_assert,
	input  wire logic        detect_above_deassert,
	output logic             low_voltage_interrupt,
	output logic      [2:0]  regulator_mode
);
	// ----------------------------------------
	// input synchronisers
	// ----------------------------------------
	logic [3:0] sync1_reg, sync1_next, sync2_reg, sync2_next;
	always_comb begin
		sync1_next = {regulator_enable_pin, stop_mode, detect_below_assert, detect_above_deassert};
		sync2_next = sync1_reg;
	end
	always_ff @(posedge mclk) begin
		if (reset) begin
			sync1_reg <= 4'h0;
			sync2_reg <= 4'h0;
		end else begin
			sync1_reg <= sync1_next;
			sync2_reg <= sync2_next;
		end
	end
	logic en_s, stop_s, below_s, above_s;
	assign {en_s, stop_s, below_s, above_s} = sync2_reg;

	// ----------------------------------------
	// mode and detector
	// ----------------------------------------
	lvdc_pkg::lvdc_mode_t mode_reg, mode_next;
	logic status_reg, status_next, en_reg, en_next, flag_reg, flag_next;
	logic waitdone_reg, waitdone_next;
	logic [31:0] rdata_reg, rdata_next;

	function automatic logic hit(input logic [1:0] a);
		hit = (a == lvdc_pkg::CTRL_OFFSET);
	endfunction

	// control word as software sees it; upper bits stay zero
	function automatic logic [31:0] ctrl_word(input logic s, input logic e, input logic f);
		ctrl_word                         = lvdc_pkg::UNMAPPED_DATA;
		ctrl_word[lvdc_pkg::STATUS_BIT]   = s;
		ctrl_word[lvdc_pkg::IRQ_EN_BIT]   = e;
		ctrl_word[lvdc_pkg::IRQ_FLAG_BIT] = f;
	endfunction

	// ----------------------------------------
	// bus request carrier
	// ----------------------------------------
	lvdc_pkg::lvdc_req_t req;
	assign req.read       = avs_read;
	assign req.write      = avs_write;
	assign req.address    = avs_address;
	assign req.byteenable = avs_byteenable;
	assign req.writedata  = avs_writedata;

	logic wr_acc, rd_acc, hit_ctrl, clr_req;
	// one wait state: the access completes on the cycle after it appears
	assign wr_acc   = req.write && waitdone_reg;
	assign rd_acc   = req.read && waitdone_reg;
	// lane 0 holds the whole register, so a write without it is refused
	assign hit_ctrl = hit(req.address) && req.byteenable[lvdc_pkg::CTRL_LANE];
	assign clr_req  = wr_acc && hit_ctrl && req.writedata[lvdc_pkg::IRQ_FLAG_BIT];

	always_comb begin
		// pin assumed static while powered, so mode is simply followed
		if (!en_s)
			mode_next = lvdc_pkg::LVDC_SHUTDOWN;
		else if (stop_s)
			mode_next = lvdc_pkg::LVDC_REDUCED;
		else
			mode_next = lvdc_pkg::LVDC_FULL_PERF;
		status_next = status_reg;
		if (mode_reg != lvdc_pkg::LVDC_FULL_PERF)
			status_next = 1'h0;
		else if (below_s)
			status_next = 1'h1;
		else if (above_s)
			status_next = 1'h0;
		en_next = en_reg;
		if (wr_acc && hit_ctrl)
			en_next = req.writedata[lvdc_pkg::IRQ_EN_BIT];
		// set wins over a simultaneous clear; mode entry never clears
		flag_next = flag_reg;
		if (clr_req)
			flag_next = 1'h0;
		if (status_next != status_reg)
			flag_next = 1'h1;
		waitdone_next = (req.read || req.write) && !waitdone_reg;
		rdata_next = rdata_reg;
		if (rd_acc) begin
			rdata_next = lvdc_pkg::UNMAPPED_DATA;
			if (hit(req.address))
				rdata_next = ctrl_word(status_reg, en_reg, flag_reg);
		end
	end
	always_ff @(posedge mclk) begin
		if (reset) begin
			mode_reg     <= lvdc_pkg::LVDC_SHUTDOWN;
			status_reg   <= lvdc_pkg::CTRL_RESET[lvdc_pkg::STATUS_BIT];
			en_reg       <= lvdc_pkg::CTRL_RESET[lvdc_pkg::IRQ_EN_BIT];
			flag_reg     <= lvdc_pkg::CTRL_RESET[lvdc_pkg::IRQ_FLAG_BIT];
			waitdone_reg <= 1'h0;
			rdata_reg    <= lvdc_pkg::UNMAPPED_DATA;
		end else begin
			mode_reg     <= mode_next;
			status_reg   <= status_next;
			en_reg       <= en_next;
			flag_reg     <= flag_next;
			waitdone_reg <= waitdone_next;
			rdata_reg    <= rdata_next;
		end
	end

	assign avs_waitrequest       = (req.read || req.write) && !waitdone_reg;
	assign avs_readdata          = rd_acc ? rdata_next : rdata_reg;
	assign low_voltage_interrupt = en_reg && flag_reg;
	assign regulator_mode        = mode_reg;

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	sequence status_moves;
		status_reg != $past(status_reg);
	endsequence
	status_fpm_a: assert property (@(posedge mclk) disable iff (reset)
		status_reg |-> $past(mode_reg) == lvdc_pkg::LVDC_FULL_PERF)
		else $error("status set outside full performance");
	status_idle_a: assert property (@(posedge mclk) disable iff (reset)
		$past(mode_reg) != lvdc_pkg::LVDC_FULL_PERF |-> !status_reg)
		else $error("status active while detector idle");
	flag_on_change_a: assert property (@(posedge mclk) disable iff (reset)
		status_moves |-> flag_reg)
		else $error("status change missed");
	flag_clear_a: assert property (@(posedge mclk) disable iff (reset)
		$fell(flag_reg) |-> $past(clr_req))
		else $error("flag cleared without write one");
	irq_gate_a: assert property (@(posedge mclk) disable iff (reset)
		low_voltage_interrupt == (en_reg && flag_reg))
		else $error("interrupt gating wrong");
	shutdown_a: assert property (@(posedge mclk) disable iff (reset)
		!en_s |=> mode_reg == lvdc_pkg::LVDC_SHUTDOWN)
		else $error("shutdown not selected");
	reduced_a: assert property (@(posedge mclk) disable iff (reset)
		en_s && stop_s |=> mode_reg == lvdc_pkg::LVDC_REDUCED)
		else $error("reduced power not selected");
	rd_upper_a: assert property (@(posedge mclk) disable iff (reset)
		rd_acc |-> avs_readdata[31:3] == 29'h0)
		else $error("upper bits not zero");
	wait_one_a: assert property (@(posedge mclk) disable iff (reset)
		$rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
		else $error("read did not finish in one wait state");

	// ----------------------------------------
	// detector and flag steps
	// ----------------------------------------
	sequence detect_low;
		mode_reg == lvdc_pkg::LVDC_FULL_PERF && below_s;
	endsequence

	sequence detect_high;
		mode_reg == lvdc_pkg::LVDC_FULL_PERF && !below_s && above_s;
	endsequence

	sequence detect_band;
		mode_reg == lvdc_pkg::LVDC_FULL_PERF && !below_s && !above_s;
	endsequence

	sequence enters_reduced;
		mode_reg == lvdc_pkg::LVDC_REDUCED && $past(mode_reg) != lvdc_pkg::LVDC_REDUCED;
	endsequence

	sequence ctrl_read;
		rd_acc && hit(req.address);
	endsequence

	sequence stray_read;
		rd_acc && !hit(req.address);
	endsequence

	status_set_a: assert property (@(posedge mclk) disable iff (reset)
		detect_low |=> status_reg)
		else $error("status not set below assert level");

	status_clr_a: assert property (@(posedge mclk) disable iff (reset)
		detect_high |=> !status_reg)
		else $error("status not cleared above deassert level");

	status_band_a: assert property (@(posedge mclk) disable iff (reset)
		detect_band |=> $stable(status_reg))
		else $error("status moved inside hysteresis band");

	status_cause_a: assert property (@(posedge mclk) disable iff (reset)
		status_moves |-> $past(below_s || above_s || mode_reg != lvdc_pkg::LVDC_FULL_PERF))
		else $error("status moved without detector cause");

	status_shut_a: assert property (@(posedge mclk) disable iff (reset)
		mode_reg == lvdc_pkg::LVDC_SHUTDOWN |=> !status_reg)
		else $error("status set in shutdown");

	flag_rise_a: assert property (@(posedge mclk) disable iff (reset)
		$rose(flag_reg) |-> status_moves)
		else $error("flag set without status change");

	flag_keep_a: assert property (@(posedge mclk) disable iff (reset)
		flag_reg && !clr_req |=> flag_reg)
		else $error("flag lost without write one");

	flag_zero_a: assert property (@(posedge mclk) disable iff (reset)
		wr_acc && hit_ctrl && !req.writedata[lvdc_pkg::IRQ_FLAG_BIT] && flag_reg |=> flag_reg)
		else $error("writing zero cleared the flag");

	flag_rpm_a: assert property (@(posedge mclk) disable iff (reset)
		enters_reduced ##0 ($past(flag_reg) && !$past(clr_req)) |-> flag_reg)
		else $error("flag cleared on entering reduced power");

	flag_set_wins_a: assert property (@(posedge mclk) disable iff (reset)
		clr_req && status_next != status_reg |=> flag_reg)
		else $error("clear beat a status change");

	// ----------------------------------------
	// register and interrupt checks
	// ----------------------------------------
	en_write_a: assert property (@(posedge mclk) disable iff (reset)
		wr_acc && hit_ctrl |=> en_reg == $past(req.writedata[lvdc_pkg::IRQ_EN_BIT]))
		else $error("enable write not stored");

	en_hold_a: assert property (@(posedge mclk) disable iff (reset)
		!(wr_acc && hit_ctrl) |=> $stable(en_reg))
		else $error("enable changed without accepted write");

	irq_off_a: assert property (@(posedge mclk) disable iff (reset)
		!en_reg |-> !low_voltage_interrupt)
		else $error("request while disabled");

	irq_on_a: assert property (@(posedge mclk) disable iff (reset)
		$rose(flag_reg) && en_reg |-> low_voltage_interrupt)
		else $error("enabled flag raised no request");

	rd_status_a: assert property (@(posedge mclk) disable iff (reset)
		ctrl_read |-> avs_readdata[lvdc_pkg::STATUS_BIT] == status_reg)
		else $error("status bit read wrong");

	rd_ctrl_a: assert property (@(posedge mclk) disable iff (reset)
		ctrl_read |-> avs_readdata[lvdc_pkg::IRQ_EN_BIT] == en_reg
			&& avs_readdata[lvdc_pkg::IRQ_FLAG_BIT] == flag_reg)
		else $error("control bits read wrong");

	rd_stray_a: assert property (@(posedge mclk) disable iff (reset)
		stray_read |-> avs_readdata == lvdc_pkg::UNMAPPED_DATA)
		else $error("unmapped read not zero");

	rd_hold_a: assert property (@(posedge mclk) disable iff (reset)
		ctrl_read ##1 !rd_acc |-> $stable(avs_readdata))
		else $error("read data not held");

	wr_wait_a: assert property (@(posedge mclk) disable iff (reset)
		$rose(avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
		else $error("write did not finish in one wait state");

	// ----------------------------------------
	// operating mode checks
	// ----------------------------------------
	mode_full_a: assert property (@(posedge mclk) disable iff (reset)
		en_s && !stop_s |=> mode_reg == lvdc_pkg::LVDC_FULL_PERF)
		else $error("full performance not selected");

	mode_onehot_a: assert property (@(posedge mclk) disable iff (reset)
		$onehot(mode_reg))
		else $error("mode code not one-hot");

	mode_out_a: assert property (@(posedge mclk) disable iff (reset)
		regulator_mode == mode_reg)
		else $error("mode output differs from mode state");
endmodule
`default_nettype wire

// >>> lvdc_pkg.sv
// Contract
// - bit 2 of the control register is a read-only copy of the detector status and writes do not change it.
// - in full performance mode the status is set below the assert level, cleared above the deassert level and held in between; it is zero in other modes.
// - the enable bit at bit 1 gates the request, which is raised whenever the flag is set and enabled.
// - the flag at bit 0 is set on every rising or falling change of the status bit.
// - the flag is cleared only by writing one to it, writing zero does nothing.
// - entering reduced power mode never clears the flag, but it sets the flag when the status drops from one to zero.
// - the detector updates the status only in full performance mode and is idle otherwise.
// - a low regulator enable pin selects shutdown, a high one selects full performance or reduced power.
// - the single control register decodes at offset 0x0000 and is readable and writable.
// - stop mode selects reduced power, otherwise full performance when the enable pin is high.
package lvdc_pkg;
	localparam logic [1:0] CTRL_OFFSET   = 2'h0;
	localparam int         STATUS_BIT    = 2;
	localparam int         IRQ_EN_BIT    = 1;
	localparam int         IRQ_FLAG_BIT  = 0;
	localparam int         CTRL_LANE     = 0;
	localparam logic [7:0] CTRL_RESET    = 8'h00;
	localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

	typedef enum logic [2:0] {
		LVDC_SHUTDOWN  = 3'h1,
		LVDC_FULL_PERF = 3'h2,
		LVDC_REDUCED   = 3'h4
	} lvdc_mode_t;

	typedef struct packed {
		logic       read;
		logic       write;
		logic [1:0] address;
		logic [3:0] byteenable;
		logic [31:0] writedata;
	} lvdc_req_t;
endpackage

// >>> lvdc_supply_model.sv
`timescale 1ns/10ps
`default_nettype none
module lvdc_supply_model (
	input  wire logic [1:0] level,
	output logic            below_assert,
	output logic            above_deassert
);
	// ----------
	// level 0 low, 1 inside the hysteresis band, 2 high
	// ----------
	assign below_assert   = (level == 2'h0);
	assign above_deassert = (level == 2'h2);
endmodule
`default_nettype wire

// >>> lvdc_top_tb.sv
`timescale 1ns/10ps
`default_nettype none
module lvdc_top_tb;
	logic        mclk, reset, rd, wr, pin, stop, w, irq, lo, hi;
	logic [1:0]  adr, lvl;
	logic [2:0]  mode;
	logic [3:0]  be;
	logic [31:0] wd, rdat, q;
	int          n_errors, num_checks, cyc;
	// ----------
	// harness
	// ----------
	initial begin
		mclk = 0;
		forever #5 mclk = ~mclk;
	end
	lvdc_supply_model lvdc_supply_model_i (.level(lvl), .below_assert(lo), .above_deassert(hi));
	lvdc_top lvdc_top_i (.mclk(mclk), .reset(reset), .avs_address(adr), .avs_read(rd),
		.avs_write(wr), .avs_byteenable(be), .avs_writedata(wd), .avs_readdata(rdat),
		.avs_waitrequest(w), .regulator_enable_pin(pin), .stop_mode(stop),
		.detect_below_assert(lo), .detect_above_deassert(hi),
		.low_voltage_interrupt(irq), .regulator_mode(mode));
	task automatic summarize();
		if (n_errors == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 3000) begin
			n_errors++;
			summarize();
		end
	end
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		num_checks++;
		if (s !== e) begin
			n_errors++;
			$display("Error %0t: saw %h expected %h", $time, s, e);
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge mclk);
	endtask
	// one request held until waitrequest is sampled low
	task automatic bus(input logic r, input logic [1:0] a, input logic [31:0] d);
		int n;
		n = 0;
		rd <= r;
		wr <= ~r;
		adr <= a;
		wd <= d;
		do begin
			@(posedge mclk);
			n++;
		end while (w !== 1'h0);
		q = rdat;
		rd <= 1'h0;
		wr <= 1'h0;
		chk(n, 2);
		@(posedge mclk);
	endtask
	// ----------
	// scenarios
	// ----------
	task automatic t_regs();
		chk(mode, lvdc_pkg::LVDC_FULL_PERF);
		bus(1, 0, 0); chk(q, 32'h0);
		bus(0, 0, 32'hFFFF_FFFE);
		bus(1, 0, 0); chk(q, 32'h2);
	endtask
	task automatic t_detect();
		lvl <= 0; wt(8);
		chk(irq, 1);
		bus(1, 0, 0); chk(q, 32'h7);
		bus(0, 0, 32'h2); bus(1, 0, 0); chk(q, 32'h7);
		bus(0, 0, 32'h3); bus(1, 0, 0); chk(q, 32'h6);
		lvl <= 1; wt(8); bus(1, 0, 0); chk(q, 32'h6);
		lvl <= 2; wt(8); bus(1, 0, 0); chk(q, 32'h3);
		bus(0, 0, 32'h0); chk(irq, 0);
		bus(1, 0, 0); chk(q, 32'h1);
		bus(0, 0, 32'h3);
	endtask
	task automatic t_stop();
		lvl <= 0; wt(8); bus(0, 0, 32'h3);
		stop <= 1; wt(8);
		chk(mode, lvdc_pkg::LVDC_REDUCED);
		bus(1, 0, 0); chk(q, 32'h3);
		bus(0, 0, 32'h3); lvl <= 2; wt(8); lvl <= 0; wt(8);
		bus(1, 0, 0); chk(q, 32'h2);
		stop <= 0; wt(8); bus(1, 0, 0); chk(q, 32'h7);
	endtask
	task automatic t_unmapped();
		bus(0, 1, 32'h1); bus(1, 1, 0); chk(q, 32'h0);
		bus(1, 0, 0); chk(q, 32'h7);
		be <= 4'h0;
		bus(0, 0, 32'h1);
		be <= 4'hF;
		bus(1, 0, 0); chk(q, 32'h7);
	endtask
	initial begin
		{reset, rd, wr, stop, adr, wd, n_errors, num_checks, cyc} = '0;
		reset = 1;
		pin = 1; // held static while powered
		be = 4'hF;
		lvl = 2;
		wt(5);
		chk(mode, lvdc_pkg::LVDC_SHUTDOWN);
		reset <= 0;
		wt(5);
		t_regs();
		t_detect();
		t_stop();
		t_unmapped();
		summarize();
	end
endmodule
`default_nettype wire
